// *** pwm_gen_pkg.sv ***
// Package holding register map, field layout and timing constants of the PWM generator.
package pwm_gen_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PERIOD_LIMIT = 8'h00;
    localparam logic [7:0] OFS_TIMER2_CONTROL = 8'h04;
    localparam logic [7:0] OFS_DUTY_HIGH_WRITE = 8'h08;
    localparam logic [7:0] OFS_DUTY_ACTIVE_COPY = 8'h0C;
    localparam logic [7:0] OFS_CCP_CONTROL = 8'h10;
    localparam logic [7:0] OFS_TIMER2_COUNT = 8'h14;
    localparam logic [7:0] OFS_DEADBAND_CONTROL = 8'h18;
    localparam logic [7:0] OFS_PERIPHERAL_FLAGS_ONE = 8'h1C;
    localparam logic [7:0] OFS_PIN_DIRECTION = 8'h20;
    localparam logic [7:0] OFS_PULSE_STEERING = 8'h24;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CCP_CONFIG_HI = 7;
    localparam int CCP_CONFIG_LO = 6;
    localparam int CCP_DUTY_LO_HI = 5;
    localparam int CCP_DUTY_LO_LO = 4;
    localparam int T2_RUN_BIT = 2;
    localparam int T2_PRESCALE_HI = 1;
    localparam int MATCH_FLAG_BIT = 1;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [7:0] PERIOD_LIMIT_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] PIN_DIRECTION_RESET = 4'hF;
    localparam logic [3:0] STEERING_RESET = 4'h1;
    localparam logic [1:0] CFG_SINGLE = 2'h0;
    localparam logic [1:0] CFG_FORWARD = 2'h1;
    localparam logic [1:0] CFG_HALF = 2'h2;
    localparam logic [1:0] CFG_REVERSE = 2'h3;
    localparam logic [1:0] PWM_MODE_TOP = 2'h3;
    // System clock phases per timer tick, and prescale ratios.
    localparam logic [1:0] QUARTER_LAST = 2'h3;
    localparam logic [3:0] PRESCALE_LAST_4 = 4'h3;
    localparam logic [3:0] PRESCALE_LAST_16 = 4'hF;
endpackage

// *** enhanced_pwm_generator.sv ***
// Enhanced PWM generator with timer, double-buffered duty, bridge steering and APB registers.
`timescale 1ns/1ps
// Notes on behaviour
// - Period is (limit+1) times 4 times prescale.
// - Match clears count, sets output unless duty is zero, loads duty.
// - Postscaler never affects the period.
// - Duty is eight high bits plus two low.
// - New duty applies only at period match.
// - Active duty copy is read-only in PWM mode.
// - High time equals duty times prescaled clock.
// - Active duty plus hidden latch double-buffer.
// - Time base is count with two phase or prescaler bits.
// - Time base equal duty drives output inactive.
// - Resolution grows with period limit up to ten.
// - Duty beyond period keeps level all period.
// - Prescaler divides by 1, 4 or 16.
// - Sleep freezes timer and pin levels; bus access still works.
// - Reset makes pins inputs, registers default.
// - Zero control releases every output pin.
// - Config field picks single, half or bridge.
// - Enable waits for a new period start.
// - Mode field picks output polarity.
// - Single mode drives pins steering enables.
// - Unused pins stay free, undriven.
// - Bridge forward and reverse pin roles.
// - Polarity chosen per pair A/C and B/D.
// - Half-bridge delays active edges by dead band.
// - Direction change parks modulated pins first.
module enhanced_pwm_generator
    import pwm_gen_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sleep,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic outPinA,
    output logic outPinB,
    output logic outPinC,
    output logic outPinD,
    output logic [3:0] pinOutEnableN,
    output logic [3:0] pinOwned
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_RUN} phase_e;
    typedef struct packed {
        // Software-visible registers and the hidden duty latch.
        logic [7:0] periodLimit;
        logic [7:0] timer2Control;
        logic [7:0] dutyHighWrite;
        logic [7:0] dutyActiveCopy;
        logic [1:0] dutyLatch;
        logic [7:0] ccpControl;
        logic [7:0] timer2Count;
        logic [7:0] deadbandControl;
        logic matchFlag;
        logic [3:0] pinDirection;
        logic [3:0] steering;

        // Timer phase and prescaler count.
        logic [1:0] quarter;
        logic [3:0] prescale;

        // Waveform, steering and pin levels.
        logic pwmOut;
        logic [1:0] bridgeCfg;
        logic parked;
        logic [6:0] deadA;
        logic [6:0] deadB;
        logic [3:0] pinVal;
        phase_e phase;

        // Bus answer.
        logic [31:0] rdata;
        logic ready;
        logic err;
    } state_s;
    state_s s_q;
    state_s s_d;
    logic tick;
    logic wrap;
    logic pwmMode;
    logic [9:0] dutyActive;
    logic [9:0] dutyRequest;
    logic [1:0] reqCfg;
    logic [3:0] polarLevels;
    logic [3:0] idleLevels;
    logic [3:0] prescaleLast;
    logic [3:0] used;
    logic [3:0] levels;
    logic mod;
    logic modA;
    logic modB;
    logic known;
    logic access;

    // True for every mapped register offset.
    function automatic logic is_reg(input logic [7:0] a);
        return a == OFS_PERIOD_LIMIT || a == OFS_TIMER2_CONTROL || a == OFS_DUTY_HIGH_WRITE ||
            a == OFS_DUTY_ACTIVE_COPY || a == OFS_CCP_CONTROL || a == OFS_TIMER2_COUNT ||
            a == OFS_DEADBAND_CONTROL || a == OFS_PERIPHERAL_FLAGS_ONE || a == OFS_PIN_DIRECTION ||
            a == OFS_PULSE_STEERING;
    endfunction

    // low bits from quarter phase or prescaler
    function automatic logic [9:0] time_base(input logic [7:0] count, input logic [1:0] phase4,
        input logic [3:0] pre, input logic [3:0] last);
        logic [9:0] base;
        base = {count, pre[3:2]};
        if (last == 4'h0) begin
            base = {count, phase4};
        end else if (last == PRESCALE_LAST_4) begin
            base = {count, pre[1:0]};
        end
        return base;
    endfunction

    // ------------------------------------------------------------
    // Time base
    // ------------------------------------------------------------
    assign pwmMode = s_q.ccpControl[3:2] == PWM_MODE_TOP;
    // A transfer is taken once; the pready pulse itself blocks a second take.
    assign access = psel && penable && !s_q.ready;
    assign known = is_reg(paddr);
    always_comb begin
        prescaleLast = 4'h0;
        if (s_q.timer2Control[T2_PRESCALE_HI]) begin
            prescaleLast = PRESCALE_LAST_16;
        end else if (s_q.timer2Control[0]) begin
            prescaleLast = PRESCALE_LAST_4;
        end
    end

    // One timer step every four clocks times the prescale ratio.
    // four phases times prescale per count
    assign tick = s_q.timer2Control[T2_RUN_BIT] && !sleep && s_q.quarter == QUARTER_LAST &&
        s_q.prescale == prescaleLast;
    assign wrap = tick && s_q.timer2Count == s_q.periodLimit;
    assign dutyActive = {s_q.dutyActiveCopy, s_q.dutyLatch};
    assign dutyRequest = {s_q.dutyHighWrite, s_q.ccpControl[CCP_DUTY_LO_HI:CCP_DUTY_LO_LO]};
    assign reqCfg = s_q.ccpControl[CCP_CONFIG_HI:CCP_CONFIG_LO];
    // output high while time base below duty
    assign mod = s_q.pwmOut;

    // ------------------------------------------------------------
    // Output steering
    // ------------------------------------------------------------
    // dead band delays each half-bridge active edge
    assign modA = mod && s_q.deadA == 7'h00;
    assign modB = !mod && s_q.deadB == 7'h00;
    always_comb begin
        used = 4'h0;
        levels = 4'h0;
        case (s_q.bridgeCfg)
            CFG_SINGLE: begin
                used = s_q.steering;
                levels = {4{mod}};
            end
            // half bridge on A and B
            CFG_HALF: begin
                used = 4'h3;
                levels[0] = modA;
                levels[1] = modB;
            end
            CFG_FORWARD: begin
                used = 4'hF;
                levels[0] = 1'b1;
                levels[3] = mod && !s_q.parked;
            end
            // Reverse: C active, B modulated, A and D stay inactive.
            default: begin
                used = 4'hF;
                levels[1] = mod && !s_q.parked;
                levels[2] = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Pin polarity
    // ------------------------------------------------------------
    // polarity per pin pair
    // mode field selects polarity
    // Bit 0 of the mode field serves pins A and C, bit 1 pins B and D; a one makes the pair active low.
    for (genvar g = 0; g < 4; g++) begin : g_polarity
        assign polarLevels[g] = levels[g] ^ s_q.ccpControl[g % 2];
        assign idleLevels[g] = s_q.ccpControl[g % 2];
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [9:0] nextBase;
        nextBase = 10'h000;
        s_d = s_q;
        s_d.ready = 1'b0;
        s_d.err = 1'b0;
        if (!sleep && s_q.timer2Control[T2_RUN_BIT]) begin
            s_d.quarter = s_q.quarter + 2'h1;
            if (s_q.quarter == QUARTER_LAST) begin
                s_d.prescale = (s_q.prescale == prescaleLast) ? 4'h0 : s_q.prescale + 4'h1;
            end
            if (tick) begin
                s_d.timer2Count = s_q.timer2Count + 8'h01;
            end

            // Clearing on the base of the coming cycle keeps the pulse exactly duty steps long.
            nextBase = time_base(s_d.timer2Count, s_d.quarter, s_d.prescale, prescaleLast);
            if (s_q.phase == ST_RUN && nextBase == dutyActive) begin
                s_d.pwmOut = 1'b0;
            end

            // Dead band counters run down only while the timer runs.
            if (s_q.deadA != 7'h00) begin
                s_d.deadA = s_q.deadA - 7'h01;
            end
            if (s_q.deadB != 7'h00) begin
                s_d.deadB = s_q.deadB - 7'h01;
            end

            if (s_q.bridgeCfg != reqCfg) begin
                s_d.parked = 1'b1;
            end
            if (s_q.pwmOut && !s_d.pwmOut) begin
                s_d.deadB = s_q.deadbandControl[6:0];
            end

            // The wrap comes after the clear so that a new period wins.
            // match clears count, sets pin unless duty is zero, loads duty
            // new duty only at period end
            if (wrap) begin
                s_d.timer2Count = BYTE_ZERO;
                s_d.dutyActiveCopy = s_q.dutyHighWrite;
                s_d.dutyLatch = s_q.ccpControl[CCP_DUTY_LO_HI:CCP_DUTY_LO_LO];
                s_d.matchFlag = 1'b1;
                s_d.parked = 1'b0;
                s_d.bridgeCfg = reqCfg;
                // waveform starts at a new period
                if (pwmMode) begin
                    s_d.phase = ST_RUN;
                    s_d.pwmOut = dutyRequest != 10'h000;
                    s_d.deadA = s_d.pwmOut ? s_q.deadbandControl[6:0] : 7'h00;
                end
            end
        end

        if (!pwmMode) begin
            s_d.phase = (s_q.ccpControl == BYTE_ZERO) ? ST_IDLE : ST_WAIT;
            s_d.pwmOut = 1'b0;
        end else if (s_q.phase == ST_IDLE) begin
            s_d.phase = ST_WAIT;
        end

        // Pins show their inactive level until the first full period starts.
        s_d.pinVal = polarLevels;
        if (s_q.phase != ST_RUN) begin
            s_d.pinVal = idleLevels;
        end
        // Sleep holds whatever the pins were driving.
        if (sleep) begin
            s_d.pinVal = s_q.pinVal;
        end

        // Register access is answered at the edge after it is taken.
        if (access) begin
            s_d.ready = 1'b1;
            s_d.err = !known;
            s_d.rdata = 32'h0000_0000;
            if (pwrite && known) begin
                if (paddr == OFS_PERIOD_LIMIT) begin
                    s_d.periodLimit = pwdata[7:0];
                end else if (paddr == OFS_TIMER2_CONTROL) begin
                    s_d.timer2Control = pwdata[7:0];
                end else if (paddr == OFS_DUTY_HIGH_WRITE) begin
                    s_d.dutyHighWrite = pwdata[7:0];
                end else if (paddr == OFS_DUTY_ACTIVE_COPY) begin
                    if (!pwmMode) begin
                        s_d.dutyActiveCopy = pwdata[7:0];
                    end
                end else if (paddr == OFS_CCP_CONTROL) begin
                    s_d.ccpControl = pwdata[7:0];
                end else if (paddr == OFS_TIMER2_COUNT) begin
                    s_d.timer2Count = pwdata[7:0];
                end else if (paddr == OFS_DEADBAND_CONTROL) begin
                    s_d.deadbandControl = pwdata[7:0];
                end else if (paddr == OFS_PERIPHERAL_FLAGS_ONE) begin
                    // A match in the same cycle wins over a software clear.
                    s_d.matchFlag = pwdata[MATCH_FLAG_BIT] || wrap;
                end else if (paddr == OFS_PIN_DIRECTION) begin
                    s_d.pinDirection = pwdata[3:0];
                end else begin
                    s_d.steering = pwdata[3:0];
                end
            end else if (!pwrite) begin
                if (paddr == OFS_PERIOD_LIMIT) begin
                    s_d.rdata[7:0] = s_q.periodLimit;
                end else if (paddr == OFS_TIMER2_CONTROL) begin
                    s_d.rdata[7:0] = s_q.timer2Control;
                end else if (paddr == OFS_DUTY_HIGH_WRITE) begin
                    s_d.rdata[7:0] = s_q.dutyHighWrite;
                end else if (paddr == OFS_DUTY_ACTIVE_COPY) begin
                    s_d.rdata[7:0] = s_q.dutyActiveCopy;
                end else if (paddr == OFS_CCP_CONTROL) begin
                    s_d.rdata[7:0] = s_q.ccpControl;
                end else if (paddr == OFS_TIMER2_COUNT) begin
                    s_d.rdata[7:0] = s_q.timer2Count;
                end else if (paddr == OFS_DEADBAND_CONTROL) begin
                    s_d.rdata[7:0] = s_q.deadbandControl;
                end else if (paddr == OFS_PERIPHERAL_FLAGS_ONE) begin
                    s_d.rdata[MATCH_FLAG_BIT] = s_q.matchFlag;
                end else if (paddr == OFS_PIN_DIRECTION) begin
                    s_d.rdata[3:0] = s_q.pinDirection;
                end else if (paddr == OFS_PULSE_STEERING) begin
                    s_d.rdata[3:0] = s_q.steering;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // reset restores defaults and inputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            // Everything clears except the few registers with non-zero defaults.
            s_q <= '0;
            s_q.periodLimit <= PERIOD_LIMIT_RESET;
            s_q.pinDirection <= PIN_DIRECTION_RESET;
            s_q.steering <= STEERING_RESET;
            s_q.phase <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Pins and bus answer
    // ------------------------------------------------------------
    assign outPinA = s_q.pinVal[0];
    assign outPinB = s_q.pinVal[1];
    assign outPinC = s_q.pinVal[2];
    assign outPinD = s_q.pinVal[3];
    // pins drive only once software clears direction
    assign pinOwned = (s_q.phase == ST_IDLE) ? 4'h0 : used;
    // A driver is enabled only on owned pins that software has made outputs.
    assign pinOutEnableN = ~(pinOwned & ~s_q.pinDirection);
    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
endmodule

// *** pwm_gen_assertions.sv ***
// Concurrent checks on the PWM generator bus and pin ports.
`timescale 1ns/1ps
module pwm_gen_assertions (
    input wire logic mclk,
    input wire logic rst,
    input wire logic sleep,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic outPinA,
    input wire logic outPinB,
    input wire logic outPinC,
    input wire logic outPinD,
    input wire logic [3:0] pinOutEnableN,
    input wire logic [3:0] pinOwned
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_ready_follows;
        s_access |=> s_answer;
    endproperty
    property p_ready_cause;
        pready |-> $past(psel && penable);
    endproperty
    property p_err_with_ready;
        pslverr |-> pready;
    endproperty
    property p_read_hold;
        !pready |-> $stable(prdata);
    endproperty
    property p_sleep_freeze;
        sleep |=> $stable({outPinA, outPinB, outPinC, outPinD});
    endproperty
    property p_unowned_free;
        (~pinOwned & ~pinOutEnableN) == 4'h0;
    endproperty
    property p_reset_idle;
        $fell(rst) |-> pinOutEnableN == 4'hF && !pready;
    endproperty
    property p_err_cause;
        pslverr |-> $past(psel);
    endproperty
    a_ready_follows: assert property (p_ready_follows) else $error("pready not a single pulse after access");
    a_ready_cause: assert property (p_ready_cause) else $error("pready without access");
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    a_read_hold: assert property (p_read_hold) else $error("prdata moved between accesses");
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("pins moved in sleep");
    a_unowned_free: assert property (p_unowned_free) else $error("unowned pin driven");
    a_reset_idle: assert property (p_reset_idle) else $error("pins driven after reset");
    a_err_cause: assert property (p_err_cause) else $error("pslverr without select");
endmodule

bind enhanced_pwm_generator pwm_gen_assertions chk_u (.mclk, .rst, .sleep, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .outPinA, .outPinB, .outPinC, .outPinD, .pinOutEnableN, .pinOwned);

// *** pwm_load_model.sv ***
// Switch-driver load on pin A: settles the wire level and times the pulses.
`timescale 1ns/1ps
module pwm_load_model (
    input wire logic mclk,
    input wire logic pinIn,
    input wire logic enableN,
    output logic lvl,
    output logic [15:0] lastPeriod,
    output logic [15:0] lastHigh
);
    logic prev_q;
    logic [15:0] cnt_q;
    logic [15:0] high_q;
    // The pull-down keeps the switch off while the pin floats.
    assign lvl = enableN ? 1'b0 : pinIn;
    always_ff @(posedge mclk) begin
        prev_q <= lvl;
        if (lvl && !prev_q) begin
            lastPeriod <= cnt_q;
            lastHigh <= high_q;
            cnt_q <= 16'h0001;
            high_q <= 16'h0001;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
            high_q <= high_q + {15'h0000, lvl};
        end
    end
endmodule

// *** enhanced_pwm_generator_test.sv ***
// Self-checking bench for the enhanced PWM generator.
`timescale 1ns/1ps
module enhanced_pwm_generator_test;
    import pwm_gen_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sleep = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, outPinA, outPinB, outPinC, outPinD, lvl, err;
    logic [3:0] pinOutEnableN, pinOwned;
    logic [15:0] lastPeriod, lastHigh;
    logic [31:0] rd;
    int failCount = 0;
    int nChecks = 0;
    enhanced_pwm_generator dut_u (.mclk, .rst, .sleep, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .outPinA, .outPinB, .outPinC, .outPinD, .pinOutEnableN, .pinOwned);
    pwm_load_model load_u (.mclk, .pinIn(outPinA), .enableN(pinOutEnableN[0]), .lvl, .lastPeriod, .lastHigh);
    initial begin
        forever #20 mclk = ~mclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (pready !== 1'b1) failCount++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_rise();
        int n;
        n = 0;
        while (lvl !== 1'b0 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        while (lvl !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            n++;
        end
        @(posedge mclk);
    endtask
    task automatic t_reset();
        chk({28'h0, pinOutEnableN}, 32'h0000000F);
        apb(1'b0, OFS_PERIOD_LIMIT, 32'h0);
        chk(rd, 32'h000000FF);
        apb(1'b0, OFS_PIN_DIRECTION, 32'h0);
        chk(rd, 32'h0000000F);
        apb(1'b0, OFS_CCP_CONTROL, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 8'h40, 32'h55);
        chk({31'h0, err}, 32'h1);
        $display("test reset done");
    endtask
    task automatic t_setup();
        int n;
        n = 0;
        apb(1'b1, OFS_PERIOD_LIMIT, 32'h3);
        apb(1'b1, OFS_CCP_CONTROL, 32'h2C);
        apb(1'b1, OFS_DUTY_HIGH_WRITE, 32'h1);
        apb(1'b1, OFS_PERIPHERAL_FLAGS_ONE, 32'h0);
        apb(1'b1, OFS_TIMER2_CONTROL, 32'h4);
        rd = 32'h0;
        while (rd[MATCH_FLAG_BIT] !== 1'b1 && n < 50) begin
            apb(1'b0, OFS_PERIPHERAL_FLAGS_ONE, 32'h0);
            n++;
        end
        chk({31'h0, rd[MATCH_FLAG_BIT]}, 32'h1);
        apb(1'b1, OFS_PIN_DIRECTION, 32'hE);
        chk({28'h0, pinOutEnableN}, 32'h0000000E);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, OFS_TIMER2_CONTROL, 32'h4 | i);
            wait_rise();
            wait_rise();
            chk({16'h0, lastPeriod}, 16 << (2 * i));
            chk({16'h0, lastHigh}, 6 << (2 * i));
        end
        $display("test period done");
    endtask
    task automatic t_buffer();
        apb(1'b1, OFS_TIMER2_CONTROL, 32'h5);
        wait_rise();
        apb(1'b1, OFS_DUTY_HIGH_WRITE, 32'h2);
        wait_rise();
        chk({16'h0, lastHigh}, 32'h18);
        wait_rise();
        chk({16'h0, lastHigh}, 32'h28);
        $display("test buffer done");
    endtask
    task automatic t_modes();
        logic [7:0] ctl[5] = '{8'h2C, 8'hAC, 8'h6C, 8'hEC, 8'hED};
        logic [3:0] own[5] = '{4'h1, 4'h3, 4'hF, 4'hF, 4'hF};
        logic [3:0] msk[5] = '{4'h0, 4'h0, 4'h7, 4'hD, 4'hD};
        logic [3:0] val[5] = '{4'h0, 4'h0, 4'h1, 4'h4, 4'h1};
        apb(1'b1, OFS_DUTY_HIGH_WRITE, 32'h1);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, OFS_CCP_CONTROL, {24'h0, ctl[i]});
            repeat (200) @(posedge mclk);
            chk({28'h0, pinOwned}, {28'h0, own[i]});
            chk({28'h0, {outPinD, outPinC, outPinB, outPinA} & msk[i]}, {28'h0, val[i]});
        end
        apb(1'b1, OFS_CCP_CONTROL, 32'h0);
        @(posedge mclk);
        chk({28'h0, pinOwned}, 32'h0);
        $display("test modes done");
    endtask
    task automatic t_sleep();
        apb(1'b1, OFS_CCP_CONTROL, 32'h2C);
        repeat (200) @(posedge mclk);
        wait_rise();
        sleep <= 1'b1;
        repeat (40) @(posedge mclk);
        chk({31'h0, lvl}, 32'h1);
        sleep <= 1'b0;
        wait_rise();
        chk({16'h0, lastPeriod}, 32'h68);
        chk({16'h0, lastHigh}, 32'h40);
        $display("test sleep done");
    endtask
    task automatic t_limits();
        apb(1'b1, OFS_DUTY_HIGH_WRITE, 32'hFF);
        repeat (200) @(posedge mclk);
        chk({31'h0, lvl}, 32'h1);
        repeat (64) @(posedge mclk);
        chk({31'h0, lvl}, 32'h1);
        apb(1'b1, OFS_DUTY_ACTIVE_COPY, 32'h0);
        apb(1'b0, OFS_DUTY_ACTIVE_COPY, 32'h0);
        chk(rd, 32'h000000FF);
        apb(1'b1, OFS_DUTY_HIGH_WRITE, 32'h0);
        apb(1'b1, OFS_CCP_CONTROL, 32'h0C);
        repeat (200) @(posedge mclk);
        chk({31'h0, lvl}, 32'h0);
        $display("test limits done");
    endtask
    initial begin
        #400000;
        failCount++;
        test_done();
    end
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_setup();
        t_buffer();
        t_modes();
        t_sleep();
        t_limits();
        test_done();
    end
endmodule
